//--- snc_defs.vh
/*
  Constants of the switch-node configuration register bank: register numbers,
  field positions, widths and reset values.
  Assumes it is included by bare name into each design file of the bank.
*/
//
// Behaviour
// - switch clock divider, 16 bits RW, reset zero
// - reference clock divider, 16 bits RW, reset three
// - read-only JTAG identity copy, four fields
// - user code: OTP code high, metal ID low
// - lower direction table, dimensions 0 to 7
// - upper direction table, dimensions 8 to 15
// - route by highest mismatching node identifier bit
// - debug origin records core of last event
// - link status reports source target type
// - link status reports destination link number
// - external links hold writable 4-bit direction
// - every link holds writable 2-bit network number
// - status bit flags packet being discarded
// - status bits show destination and source busy
// - processor links: same fields, no direction
// - node identifier, 16 bits RW, reset zero
// - write-protect bit blocks all writes but those to switch control
`ifndef SNC_DEFS_VH
`define SNC_DEFS_VH

// ----------------------------------------
// register numbers
// ----------------------------------------
`define SNC_REG_SWITCH_CFG 8'h04
`define SNC_REG_NODE_ID 8'h05
`define SNC_REG_SWITCH_CLK_DIV 8'h07
`define SNC_REG_REF_CLK_DIV 8'h08
`define SNC_REG_JTAG_ID 8'h09
`define SNC_REG_USER_CODE 8'h0a
`define SNC_REG_DIR_LOW 8'h0c
`define SNC_REG_DIR_HIGH 8'h0d
`define SNC_REG_RSV_CTL_A 8'h10
`define SNC_REG_RSV_CTL_B 8'h11
`define SNC_REG_DEBUG_ORIGIN 8'h1f
`define SNC_REG_LINK_BASE 8'h20
`define SNC_REG_CORE_LINK_BASE 8'h40

// ----------------------------------------
// counts and widths
// ----------------------------------------
`define SNC_NUM_LINKS 9
`define SNC_NUM_CORE_LINKS 8
`define SNC_DIV_W 16
`define SNC_NODE_ID_W 16
`define SNC_DIR_W 4
`define SNC_NET_W 2
`define SNC_USER_OTP_W 14
`define SNC_METAL_ID_W 18

// ----------------------------------------
// field positions
// ----------------------------------------
`define SNC_CFG_WPROT_BIT 31
`define SNC_CFG_PLL_PROT_BIT 8
`define SNC_CFG_HDR_BIT 0
`define SNC_DBG_RSV_BIT 4
`define SNC_DBG_CORE1_BIT 1
`define SNC_DBG_CORE0_BIT 0
`define SNC_LS_TYPE_LSB 24
`define SNC_LS_DEST_LSB 16
`define SNC_LS_DIR_LSB 8
`define SNC_LS_NET_LSB 4
`define SNC_LS_JUNK_BIT 2
`define SNC_LS_DBUSY_BIT 1
`define SNC_LS_SBUSY_BIT 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define SNC_RST_SWITCH_DIV 16'h0000
`define SNC_RST_REF_DIV 16'h0003
`define SNC_RST_NODE_ID 16'h0000
`define SNC_RST_DIR_TABLE 32'h00000000

`endif

//--- snc_route_pick.v
/*
  Route direction selection: picks the direction of the most significant bit
  where a destination identifier differs from this node's identifier.
  Assumes the caller registers the result; purely combinational.
*/
`timescale 1ns/1ns
`include "snc_defs.vh"

module snc_route_pick (
  input wire [15:0] nodeId,
  input wire [15:0] destId,
  input wire [31:0] dirLow,
  input wire [31:0] dirHigh,
  output reg [3:0] dir,
  output reg sameNode
);

  // ----------------------------------------
  // highest mismatching bit
  // ----------------------------------------
  function [3:0] msbIndex;
    input [15:0] diff;
    integer k;
    begin
      msbIndex = 4'h0;
      for (k = 0; k < 16; k = k + 1) begin
        if (diff[k]) begin
          msbIndex = k[3:0];
        end
      end
    end
  endfunction

  reg [15:0] diff;
  reg [3:0] dim;
  reg [63:0] dirTable;

  always @* begin
    diff = nodeId ^ destId;
    dim = msbIndex(diff);
    dirTable = {dirHigh, dirLow};
    dir = dirTable[{dim, 2'b00} +: 4];
    sameNode = (diff == 16'h0000);
  end

endmodule // snc_route_pick

//--- snc_regs.v
/*
  Switch-node configuration register bank: dividers, identity copies, route
  direction tables, debug origin and per-link status/direction/network.
  Assumes a single clock, node configuration reads and writes arriving as
  one-cycle strobes, and status inputs synchronous to clk.
*/
`timescale 1ns/1ns
`include "snc_defs.vh"

module snc_regs (
  input wire clk,
  input wire arst_n,
  input wire cfgWrite,
  input wire cfgRead,
  input wire [7:0] cfgAddr,
  input wire [31:0] cfgWdata,
  output reg [31:0] cfgRdata,
  output reg cfgRdValid,
  input wire [31:0] jtagIdCode,
  input wire [13:0] userCodeOtp,
  input wire [17:0] metalIdCode,
  input wire dbgEvent,
  input wire dbgFromCore0,
  input wire dbgFromCore1,
  input wire [17:0] linkTargetType,
  input wire [71:0] linkDestNum,
  input wire [8:0] linkJunk,
  input wire [8:0] linkDestBusy,
  input wire [8:0] linkSrcBusy,
  input wire [15:0] coreTargetType,
  input wire [63:0] coreDestNum,
  input wire [7:0] coreJunk,
  input wire [7:0] coreDestBusy,
  input wire [7:0] coreSrcBusy,
  input wire routeReq,
  input wire [15:0] routeDestId,
  output reg routeValid,
  output reg [3:0] routeDir,
  output reg routeLocal,
  output reg [15:0] switchClkDiv,
  output reg [15:0] refClkDiv,
  output reg [15:0] nodeId,
  output reg writeProtect,
  output reg pllProtect,
  output reg headerOneByte,
  output reg [31:0] dirLow,
  output reg [31:0] dirHigh,
  output reg [35:0] linkDir,
  output reg [17:0] linkNet,
  output reg [15:0] coreNet
);

  // ----------------------------------------
  // internal state
  // ----------------------------------------
  reg [1:0] rsvCtlA;
  reg [1:0] rsvCtlB;
  reg [1:0] dbgOrigin;
  reg dbgRsv;
  reg [31:0] next_rdata;
  reg wrOk;
  reg isLink;
  reg isCore;
  reg [3:0] linkIdx;
  reg [2:0] coreIdx;
  wire [3:0] pickDir;
  wire pickLocal;
  integer i;

  // ----------------------------------------
  // status word assembly, shared by both link kinds
  // ----------------------------------------
  function [31:0] statusWord;
    input [1:0] tgt;
    input [7:0] dst;
    input [3:0] dir;
    input [1:0] net;
    input junk;
    input dBusy;
    input sBusy;
    begin
      statusWord = 32'h00000000;
      statusWord[`SNC_LS_TYPE_LSB +: 2] = tgt;
      statusWord[`SNC_LS_DEST_LSB +: 8] = dst;
      statusWord[`SNC_LS_DIR_LSB +: 4] = dir;
      statusWord[`SNC_LS_NET_LSB +: 2] = net;
      statusWord[`SNC_LS_JUNK_BIT] = junk;
      statusWord[`SNC_LS_DBUSY_BIT] = dBusy;
      statusWord[`SNC_LS_SBUSY_BIT] = sBusy;
    end
  endfunction

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  always @* begin
    linkIdx = cfgAddr[3:0];
    coreIdx = cfgAddr[2:0];
    isLink = (cfgAddr[7:4] == `SNC_REG_LINK_BASE >> 4) && (cfgAddr[3:0] < 4'h9);
    isCore = (cfgAddr[7:3] == `SNC_REG_CORE_LINK_BASE >> 3);
    // protect blocks the whole bank but its own register, so it can be lifted
    wrOk = cfgWrite && (!writeProtect || cfgAddr == `SNC_REG_SWITCH_CFG);
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always @* begin
    next_rdata = 32'h00000000;
    case (cfgAddr)
      `SNC_REG_SWITCH_CFG: begin
        next_rdata[`SNC_CFG_WPROT_BIT] = writeProtect;
        next_rdata[`SNC_CFG_PLL_PROT_BIT] = pllProtect;
        next_rdata[`SNC_CFG_HDR_BIT] = headerOneByte;
      end
      `SNC_REG_NODE_ID: next_rdata[15:0] = nodeId;
      `SNC_REG_SWITCH_CLK_DIV: next_rdata[15:0] = switchClkDiv;
      `SNC_REG_REF_CLK_DIV: next_rdata[15:0] = refClkDiv;
      `SNC_REG_JTAG_ID: next_rdata = jtagIdCode;
      `SNC_REG_USER_CODE: next_rdata = {userCodeOtp, metalIdCode};
      `SNC_REG_DIR_LOW: next_rdata = dirLow;
      `SNC_REG_DIR_HIGH: next_rdata = dirHigh;
      `SNC_REG_RSV_CTL_A: next_rdata[1:0] = rsvCtlA;
      `SNC_REG_RSV_CTL_B: next_rdata[1:0] = rsvCtlB;
      `SNC_REG_DEBUG_ORIGIN: begin
        next_rdata[`SNC_DBG_RSV_BIT] = dbgRsv;
        next_rdata[1:0] = dbgOrigin;
      end
      default: begin
        if (isLink) begin
          next_rdata = statusWord(linkTargetType[linkIdx * 2 +: 2],
            linkDestNum[linkIdx * 8 +: 8], linkDir[linkIdx * 4 +: 4],
            linkNet[linkIdx * 2 +: 2], linkJunk[linkIdx], linkDestBusy[linkIdx],
            linkSrcBusy[linkIdx]);
        end else if (isCore) begin
          // direction bits forced to zero: reserved on processor links
          next_rdata = statusWord(coreTargetType[coreIdx * 2 +: 2],
            coreDestNum[coreIdx * 8 +: 8], 4'h0, coreNet[coreIdx * 2 +: 2],
            coreJunk[coreIdx], coreDestBusy[coreIdx], coreSrcBusy[coreIdx]);
        end
      end
    endcase
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfgRdata <= 32'h00000000;
      cfgRdValid <= 1'b0;
    end else begin
      cfgRdValid <= cfgRead;
      if (cfgRead) begin
        cfgRdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------
  // switch-level writable registers
  // ----------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      writeProtect <= 1'b0;
      pllProtect <= 1'b0;
      headerOneByte <= 1'b0;
      nodeId <= `SNC_RST_NODE_ID;
      switchClkDiv <= `SNC_RST_SWITCH_DIV;
      refClkDiv <= `SNC_RST_REF_DIV;
      dirLow <= `SNC_RST_DIR_TABLE;
      dirHigh <= `SNC_RST_DIR_TABLE;
      rsvCtlA <= 2'b00;
      rsvCtlB <= 2'b00;
    end else if (wrOk) begin
      case (cfgAddr)
        `SNC_REG_SWITCH_CFG: begin
          writeProtect <= cfgWdata[`SNC_CFG_WPROT_BIT];
          pllProtect <= cfgWdata[`SNC_CFG_PLL_PROT_BIT];
          headerOneByte <= cfgWdata[`SNC_CFG_HDR_BIT];
        end
        `SNC_REG_NODE_ID: nodeId <= cfgWdata[15:0];
        `SNC_REG_SWITCH_CLK_DIV: switchClkDiv <= cfgWdata[15:0];
        `SNC_REG_REF_CLK_DIV: refClkDiv <= cfgWdata[15:0];
        `SNC_REG_DIR_LOW: dirLow <= cfgWdata;
        `SNC_REG_DIR_HIGH: dirHigh <= cfgWdata;
        `SNC_REG_RSV_CTL_A: rsvCtlA <= cfgWdata[1:0];
        `SNC_REG_RSV_CTL_B: rsvCtlB <= cfgWdata[1:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // debug origin
  // ----------------------------------------
  // a hardware event in the same cycle as a software write wins, so the
  // record of the last event is never overwritten by a stale value
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dbgOrigin <= 2'b00;
      dbgRsv <= 1'b0;
    end else begin
      if (wrOk && cfgAddr == `SNC_REG_DEBUG_ORIGIN) begin
        dbgRsv <= cfgWdata[`SNC_DBG_RSV_BIT];
      end
      if (dbgEvent) begin
        dbgOrigin <= {dbgFromCore1, dbgFromCore0};
      end else if (wrOk && cfgAddr == `SNC_REG_DEBUG_ORIGIN) begin
        dbgOrigin <= {cfgWdata[`SNC_DBG_CORE1_BIT], cfgWdata[`SNC_DBG_CORE0_BIT]};
      end
    end
  end

  // ----------------------------------------
  // per-link direction and network
  // ----------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      linkDir <= 36'h000000000;
      linkNet <= 18'h00000;
      coreNet <= 16'h0000;
    end else if (wrOk) begin
      for (i = 0; i < `SNC_NUM_LINKS; i = i + 1) begin
        if (isLink && linkIdx == i[3:0]) begin
          linkDir[i * 4 +: 4] <= cfgWdata[`SNC_LS_DIR_LSB +: 4];
          linkNet[i * 2 +: 2] <= cfgWdata[`SNC_LS_NET_LSB +: 2];
        end
      end
      for (i = 0; i < `SNC_NUM_CORE_LINKS; i = i + 1) begin
        if (isCore && coreIdx == i[2:0]) begin
          coreNet[i * 2 +: 2] <= cfgWdata[`SNC_LS_NET_LSB +: 2];
        end
      end
    end
  end

  // ----------------------------------------
  // route lookup
  // ----------------------------------------
  snc_route_pick u_pick (
    .nodeId(nodeId),
    .destId(routeDestId),
    .dirLow(dirLow),
    .dirHigh(dirHigh),
    .dir(pickDir),
    .sameNode(pickLocal)
  );

  // one cycle of latency keeps the route outputs straight off flip-flops
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      routeValid <= 1'b0;
      routeDir <= 4'h0;
      routeLocal <= 1'b0;
    end else begin
      routeValid <= routeReq;
      if (routeReq) begin
        routeDir <= pickDir;
        routeLocal <= pickLocal;
      end
    end
  end

endmodule // snc_regs

//--- snc_regs_assertions.sv
/*
  Port checker for the switch-node register bank.
  Assumes it is bound to snc_regs and sees its ports only.
*/
`timescale 1ns/1ns
module snc_regs_chk (
  input wire clk,
  input wire arst_n,
  input wire cfgWrite,
  input wire cfgRead,
  input wire [7:0] cfgAddr,
  input wire [31:0] cfgWdata,
  input wire [31:0] cfgRdata,
  input wire cfgRdValid,
  input wire [31:0] jtagIdCode,
  input wire [13:0] userCodeOtp,
  input wire [17:0] metalIdCode,
  input wire routeReq,
  input wire routeValid,
  input wire [15:0] switchClkDiv,
  input wire [15:0] refClkDiv,
  input wire [15:0] nodeId,
  input wire writeProtect,
  input wire [31:0] dirLow,
  input wire [31:0] dirHigh
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // only writes that the protect bit lets through
  wire wok = cfgWrite && !writeProtect;
  AST_SW_DIV: assert property (wok && cfgAddr == 8'h07 |=>
    switchClkDiv == $past(cfgWdata[15:0])) else $error("switch divider not loaded");
  AST_REF_DIV: assert property (wok && cfgAddr == 8'h08 |=>
    refClkDiv == $past(cfgWdata[15:0])) else $error("reference divider not loaded");
  AST_JTAG: assert property (cfgRead && cfgAddr == 8'h09 |=>
    cfgRdValid && cfgRdata == $past(jtagIdCode)) else $error("identity read wrong");
  AST_USER: assert property (cfgRead && cfgAddr == 8'h0a |=> cfgRdValid &&
    cfgRdata == {$past(userCodeOtp), $past(metalIdCode)}) else $error("user code wrong");
  AST_DIR_LO: assert property (wok && cfgAddr == 8'h0c |=>
    dirLow == $past(cfgWdata)) else $error("low directions not loaded");
  AST_DIR_HI: assert property (wok && cfgAddr == 8'h0d |=>
    dirHigh == $past(cfgWdata)) else $error("high directions not loaded");
  AST_ROUTE_ACK: assert property (routeReq |=> routeValid)
    else $error("route answer missing");
  AST_NODE: assert property (wok && cfgAddr == 8'h05 |=>
    nodeId == $past(cfgWdata[15:0])) else $error("node id not loaded");
  AST_PROT: assert property (cfgWrite && writeProtect && cfgAddr != 8'h04 |=>
    $stable(switchClkDiv) && $stable(refClkDiv) && $stable(dirLow) && $stable(nodeId))
    else $error("protected write took effect");
  AST_RD_PAD: assert property (cfgRead && (cfgAddr == 8'h07 || cfgAddr == 8'h05) |=>
    cfgRdata[31:16] == 16'h0000) else $error("reserved bits not zero");
endmodule // snc_regs_chk
bind snc_regs snc_regs_chk chk_u (.clk, .arst_n, .cfgWrite, .cfgRead, .cfgAddr, .cfgWdata,
  .cfgRdata, .cfgRdValid, .jtagIdCode, .userCodeOtp, .metalIdCode, .routeReq, .routeValid,
  .switchClkDiv, .refClkDiv, .nodeId, .writeProtect, .dirLow, .dirHigh);

//--- tb_snc_regs.sv
/*
  Self-checking bench for the switch-node register bank.
  Assumes snc_regs with its checker bound; single 125 MHz clock.
*/
`timescale 1ns/1ns
module tb_snc_regs;
  logic clk = 0, arst_n = 0, cfgWrite = 0, cfgRead = 0, routeReq = 0;
  logic dbgEvent = 0, dbgFromCore0 = 0, dbgFromCore1 = 0;
  logic [7:0] cfgAddr = 8'h00, n;
  logic [31:0] cfgWdata = 32'h0, jtagIdCode = 32'h0, w, seed = 32'h0000cd36;
  logic [13:0] userCodeOtp = 14'h0;
  logic [17:0] metalIdCode = 18'h0, linkTargetType = 18'h0, linkNet;
  logic [71:0] linkDestNum = 72'h0;
  logic [8:0] linkJunk = 9'h0, linkDestBusy = 9'h0, linkSrcBusy = 9'h0;
  logic [15:0] coreTargetType = 16'h0, routeDestId = 16'h0, d;
  logic [63:0] coreDestNum = 64'h0, tab;
  logic [7:0] coreJunk = 8'h0, coreDestBusy = 8'h0, coreSrcBusy = 8'h0;
  logic [127:0] big;
  logic [7:0] ra [9] = '{8'h07, 8'h08, 8'h10, 8'h11, 8'h30, 8'h1f, 8'h0c, 8'h0d, 8'h05};
  logic [31:0] rm [9] = '{32'hffff, 32'hffff, 32'h3, 32'h3, 32'h0, 32'h13, 32'hffffffff,
    32'hffffffff, 32'hffff};
  wire [31:0] cfgRdata, dirLow, dirHigh;
  wire cfgRdValid, routeValid, routeLocal, writeProtect, pllProtect, headerOneByte;
  wire [3:0] routeDir;
  wire [15:0] switchClkDiv, refClkDiv, nodeId, coreNet;
  wire [35:0] linkDir;
  int err_total = 0, tests_run = 0, cyc = 0;
  snc_regs dut_u (.clk, .arst_n, .cfgWrite, .cfgRead, .cfgAddr, .cfgWdata, .cfgRdata,
    .cfgRdValid, .jtagIdCode, .userCodeOtp, .metalIdCode, .dbgEvent, .dbgFromCore0,
    .dbgFromCore1, .linkTargetType, .linkDestNum, .linkJunk, .linkDestBusy, .linkSrcBusy,
    .coreTargetType, .coreDestNum, .coreJunk, .coreDestBusy, .coreSrcBusy, .routeReq,
    .routeDestId, .routeValid, .routeDir, .routeLocal, .switchClkDiv, .refClkDiv, .nodeId,
    .writeProtect, .pllProtect, .headerOneByte, .dirLow, .dirHigh, .linkDir, .linkNet,
    .coreNet);
  initial forever #4 clk = ~clk;
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic [3:0] xdir(logic [15:0] a, logic [15:0] b, logic [63:0] t);
    int k;
    k = 0;
    for (int i = 0; i < 16; i++) if (a[i] ^ b[i]) k = i;
    return t[4*k +: 4];
  endfunction
  function logic [31:0] lw(logic [1:0] t, logic [7:0] ds, logic [3:0] dr, logic [1:0] nt,
    logic j, logic b, logic s);
    return {6'h0, t, ds, 4'h0, dr, 2'h0, nt, 1'b0, j, b, s};
  endfunction
  task chk(string nm, logic [63:0] s, logic [63:0] e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wr(logic [7:0] a, logic [31:0] v);
    @(posedge clk);
    cfgWrite <= 1;
    cfgAddr <= a;
    cfgWdata <= v;
    @(posedge clk);
    cfgWrite <= 0;
  endtask
  // strobe drops at the taking edge; answer is sampled once it has settled
  task rc(logic [7:0] a, logic [31:0] e);
    @(posedge clk);
    cfgRead <= 1;
    cfgAddr <= a;
    @(posedge clk);
    cfgRead <= 0;
    #1 chk("read", {cfgRdValid, cfgRdata}, {1'b1, e});
  endtask
  task end_of_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1;
    @(posedge clk);
    chk("divs", {refClkDiv, switchClkDiv}, 32'h00030000);
    chk("dirs", {dirHigh, dirLow}, 64'h0);
    chk("nets", {linkDir, linkNet}, 64'h0);
    chk("node", {coreNet, nodeId}, 64'h0);
    $display("test 1 done");
    for (int i = 0; i < 9; i++) begin
      w = rnd();
      wr(ra[i], w);
      rc(ra[i], w & rm[i]);
    end
    big = {rnd(), rnd(), rnd(), rnd()};
    @(posedge clk);
    jtagIdCode <= big[31:0];
    {userCodeOtp, metalIdCode} <= big[63:32];
    wr(8'h09, ~big[31:0]);
    rc(8'h09, big[31:0]);
    wr(8'h0a, ~big[63:32]);
    rc(8'h0a, big[63:32]);
    $display("test 2 done");
    tab = {dirHigh, dirLow};
    d = nodeId;
    tab = {rm[7] & ra[7], tab[31:0]} == tab ? tab : tab;
    for (int j = 0; j < 24; j++) begin
      w = rnd();
      @(posedge clk);
      routeReq <= 1;
      routeDestId <= j == 0 ? d ^ 16'h8000 : j == 1 ? d ^ 16'h0001 : j == 2 ? d : w[15:0];
      @(posedge clk);
      routeReq <= 0;
      #1 chk("route", {routeValid, routeLocal, routeDir},
        {1'b1, routeDestId == d, xdir(d, routeDestId, tab)});
    end
    $display("test 3 done");
    big = {rnd(), rnd(), rnd(), rnd()};
    @(posedge clk);
    linkDestNum <= big[71:0];
    coreDestNum <= big[127:64];
    big = {rnd(), rnd(), rnd(), rnd()};
    {linkTargetType, linkJunk, linkDestBusy, linkSrcBusy} <= big[44:0];
    {coreTargetType, coreJunk, coreDestBusy, coreSrcBusy} <= big[84:45];
    for (n = 0; n < 9; n++) begin
      w = rnd();
      wr(8'h20 + n, w);
      rc(8'h20 + n, lw(linkTargetType[2*n +: 2], linkDestNum[8*n +: 8], w[11:8],
        w[5:4], linkJunk[n], linkDestBusy[n], linkSrcBusy[n]));
      chk("ldir", {linkDir[4*n +: 4], linkNet[2*n +: 2]}, {w[11:8], w[5:4]});
    end
    for (n = 0; n < 8; n++) begin
      w = rnd();
      wr(8'h40 + n, w);
      rc(8'h40 + n, lw(coreTargetType[2*n +: 2], coreDestNum[8*n +: 8], 4'h0,
        w[5:4], coreJunk[n], coreDestBusy[n], coreSrcBusy[n]));
      chk("cnet", coreNet[2*n +: 2], w[5:4]);
    end
    $display("test 4 done");
    // bit 4 may still hold a random value from the first sweep
    wr(8'h1f, 32'h0);
    for (n = 0; n < 4; n++) begin
      @(posedge clk);
      dbgEvent <= 1;
      {dbgFromCore1, dbgFromCore0} <= n[1:0];
      // last round: write in the event's cycle, the event must win bits 1:0
      cfgWrite <= n == 3;
      cfgAddr <= 8'h1f;
      cfgWdata <= 32'h00000010;
      @(posedge clk);
      dbgEvent <= 0;
      cfgWrite <= 0;
      rc(8'h1f, {27'h0, n == 3, 2'h0, n[1:0]});
    end
    $display("test 5 done");
    wr(8'h07, 32'h00001234);
    wr(8'h04, 32'hffffffff);
    rc(8'h04, 32'h80000101);
    chk("cfgbits", {writeProtect, pllProtect, headerOneByte}, 3'h7);
    wr(8'h07, 32'h0000abcd);
    rc(8'h07, 32'h00001234);
    wr(8'h0c, ~tab[31:0]);
    rc(8'h0c, tab[31:0]);
    wr(8'h04, 32'h0);
    wr(8'h07, 32'h0000abcd);
    rc(8'h07, 32'h0000abcd);
    $display("test 6 done");
    // mid-run reset must bring the dividers and protect back to reset values
    @(posedge clk);
    arst_n <= 0;
    repeat (2) @(posedge clk);
    arst_n <= 1;
    @(posedge clk);
    #1 chk("rst", {refClkDiv, switchClkDiv, writeProtect}, 33'h000060000);
    rc(8'h07, 32'h00000000);
    $display("test 7 done");
    end_of_test();
  end
endmodule // tb_snc_regs
